// ### hw/tsor_top.sv
// timer serial output router: record framer, printer buffer and host link routing
`timescale 1ns/1ps

module tsor_uart_tx
  import tsor_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // byte in
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  output logic ready_out,
  // line
  output logic tx_out
);
  logic busy;
  logic [FRAME_BITS-1:0] shreg;
  logic [3:0] bit_cnt;
  logic [31:0] div;
  logic baud_en;

  assign baud_en = busy && (div == 32'(BIT_CYC_P - 1));
  assign ready_out = !busy;
  assign tx_out = shreg[0];

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div <= '0;
    end else if (!busy || baud_en) begin
      div <= '0;
    end else begin
      div <= div + 32'h1;
    end
  end

  // start bit, eight data bits lsb first, one stop bit
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      shreg <= '1;
      bit_cnt <= 4'h0;
    end else if (valid_in && !busy) begin
      busy <= 1'b1;
      shreg <= {{STOP_BITS{1'b1}}, data_in, 1'b0};
      bit_cnt <= 4'h0;
    end else if (baud_en) begin
      shreg <= {1'b1, shreg[FRAME_BITS-1:1]};
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == 4'(FRAME_BITS - 1)) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

module tsor_top
  import tsor_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC,
  parameter int RUN_CYC_P = RUN_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // host serial port
  input wire logic host_rx_in,
  output logic host_tx_out,
  // printer port
  input wire logic prn_ready_in,
  output logic prn_tx_out,
  // display port
  output logic disp_tx_out,
  // timing event records
  input wire logic evt_valid_in,
  output logic evt_ready_out,
  input wire logic [1:0] evt_kind_in,
  input wire logic [15:0] evt_unit_in,
  input wire logic [19:0] evt_seq_in,
  input wire logic [7:0] evt_chan_in,
  input wire logic evt_manual_in,
  input wire logic [47:0] evt_time_in,
  // running time of day, hh mm ss tenths in bcd
  input wire logic [27:0] tod_in,
  // status
  output logic link_prn_out,
  output logic link_disp_out,
  output logic run_en_out
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] hrx_sync;
  logic [2:0] prdy_sync;
  logic hrx_lvl;
  logic prn_rdy;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrx_sync <= 3'h7;
      prdy_sync <= 3'h0;
    end else begin
      hrx_sync <= {hrx_sync[1:0], host_rx_in};
      prdy_sync <= {prdy_sync[1:0], prn_ready_in};
    end
  end

  // a level counts only once the second and third stages agree
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrx_lvl <= 1'b1;
      prn_rdy <= 1'b0;
    end else begin
      if (hrx_sync[1] == hrx_sync[2]) begin
        hrx_lvl <= hrx_sync[2];
      end
      if (prdy_sync[1] == prdy_sync[2]) begin
        prn_rdy <= prdy_sync[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // host receiver
  // ---------------------------------------------------------------
  tsor_rx_t rx_st;
  logic [31:0] rx_div;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_valid;
  logic [7:0] rx_byte;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_st <= TSOR_RX_IDLE;
      rx_div <= '0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      rx_div <= rx_div + 32'h1;
      case (rx_st)
        TSOR_RX_IDLE: begin
          rx_div <= '0;
          if (!hrx_lvl) begin
            rx_st <= TSOR_RX_START;
          end
        end
        TSOR_RX_START: begin
          // half a bit in, so data is sampled mid-cell
          if (rx_div == 32'(BIT_CYC_P / 2 - 1)) begin
            rx_div <= '0;
            rx_bit <= 3'h0;
            rx_st <= hrx_lvl ? TSOR_RX_IDLE : TSOR_RX_DATA;
          end
        end
        TSOR_RX_DATA: begin
          if (rx_div == 32'(BIT_CYC_P - 1)) begin
            rx_div <= '0;
            rx_sh <= {hrx_lvl, rx_sh[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_st <= TSOR_RX_STOP;
            end
          end
        end
        TSOR_RX_STOP: begin
          if (rx_div == 32'(BIT_CYC_P - 1)) begin
            rx_st <= TSOR_RX_IDLE;
            rx_valid <= hrx_lvl;
            rx_byte <= rx_sh;
          end
        end
        default: rx_st <= TSOR_RX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command frames and linking
  // ---------------------------------------------------------------
  logic in_frame;
  logic [2:0] fr_len;
  logic [7:0] fr_b2;
  logic [7:0] fr_b1;
  logic [7:0] fr_b0;
  logic frame_end;
  logic frame_ok;
  logic is_lp;
  logic is_ll;
  logic is_lx;
  logic is_pl;
  logic is_p1;
  logic ack_set;
  tsor_link_t link;
  logic run_en;

  assign frame_end = rx_valid && in_frame && (rx_byte == CH_ETX);
  assign frame_ok = frame_end && (fr_len == 3'h3) && (8'(fr_b2 + fr_b1) == fr_b0);
  assign is_lp = frame_ok && ({fr_b2, fr_b1} == {CH_L, CH_P});
  assign is_ll = frame_ok && ({fr_b2, fr_b1} == {CH_L, CH_L});
  assign is_lx = frame_ok && ({fr_b2, fr_b1} == {CH_L, CH_X});
  assign is_pl = frame_ok && ({fr_b2, fr_b1} == {CH_P, CH_L});
  assign is_p1 = frame_ok && ({fr_b2, fr_b1} == {CH_P, CH_ONE});
  assign ack_set = frame_end && ((link == TSOR_LINK_NONE) || is_lx);

  // last three bytes are command letters and checksum
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_frame <= 1'b0;
      fr_len <= 3'h0;
      fr_b2 <= 8'h00;
      fr_b1 <= 8'h00;
      fr_b0 <= 8'h00;
    end else if (rx_valid) begin
      if (rx_byte == CH_STX) begin
        in_frame <= 1'b1;
        fr_len <= 3'h0;
      end else if (frame_end) begin
        in_frame <= 1'b0;
      end else if (in_frame) begin
        {fr_b2, fr_b1, fr_b0} <= {fr_b1, fr_b0, rx_byte};
        fr_len <= (fr_len == 3'h4) ? fr_len : fr_len + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      link <= TSOR_LINK_NONE;
    end else if (link == TSOR_LINK_NONE) begin
      if (is_lp) begin
        link <= TSOR_LINK_PRN;
      end else if (is_ll) begin
        link <= TSOR_LINK_DISP;
      end
    end else if (is_lx) begin
      link <= TSOR_LINK_NONE;
    end
  end

  // parameter commands are ignored while linked
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_en <= 1'b0;
    end else if (link == TSOR_LINK_NONE) begin
      if (is_pl) begin
        run_en <= 1'b1;
      end else if (is_p1) begin
        run_en <= 1'b0;
      end
    end
  end

  assign link_prn_out = (link == TSOR_LINK_PRN);
  assign link_disp_out = (link == TSOR_LINK_DISP);
  assign run_en_out = run_en;

  // ---------------------------------------------------------------
  // acknowledge to host
  // ---------------------------------------------------------------
  logic ack_pend;
  logic [7:0] ack_byte;
  logic host_rdy;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_pend <= 1'b0;
      ack_byte <= 8'h00;
    end else if (ack_set) begin
      ack_pend <= 1'b1;
      ack_byte <= (is_lp || is_ll || is_lx || is_pl || is_p1) ? CH_ACK : CH_NAK;
    end else if (host_rdy) begin
      ack_pend <= 1'b0;
    end
  end

  tsor_uart_tx #(.BIT_CYC_P(BIT_CYC_P)) u_host_tx (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .valid_in(ack_pend),
    .data_in(ack_byte),
    .ready_out(host_rdy),
    .tx_out(host_tx_out)
  );

  // ---------------------------------------------------------------
  // forwarded host text, one byte held for whichever port is linked
  // ---------------------------------------------------------------
  logic fwd_ok;
  logic fwd_prn_v;
  logic fwd_disp_v;
  logic [7:0] fwd_byte;
  logic fwd_push;
  logic fwd_disp_take;

  // a single hold byte is enough only because the host paces its text
  assign fwd_ok = rx_valid && !in_frame && (rx_byte != CH_STX);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fwd_prn_v <= 1'b0;
      fwd_disp_v <= 1'b0;
      fwd_byte <= 8'h00;
    end else begin
      if (fwd_ok && link != TSOR_LINK_NONE) begin
        fwd_byte <= rx_byte;
      end
      if (fwd_ok && link == TSOR_LINK_PRN) begin
        fwd_prn_v <= 1'b1;
      end else if (fwd_push) begin
        fwd_prn_v <= 1'b0;
      end
      if (fwd_ok && link == TSOR_LINK_DISP) begin
        fwd_disp_v <= 1'b1;
      end else if (fwd_disp_take) begin
        fwd_disp_v <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // event record framer
  // ---------------------------------------------------------------
  logic evt_busy;
  logic [4:0] ev_idx;
  logic [1:0] ev_kind;
  logic [15:0] ev_unit;
  logic [19:0] ev_seq;
  logic [7:0] ev_chan;
  logic ev_man;
  logic [47:0] ev_time;
  logic [7:0] ev_char;
  logic evt_push;

  function automatic logic [7:0] dig(input logic [3:0] d);
    return CH_ZERO + {4'h0, d};
  endfunction

  assign evt_ready_out = !evt_busy;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      evt_busy <= 1'b0;
      ev_idx <= 5'h00;
      ev_kind <= KIND_NEW;
      ev_unit <= 16'h0000;
      ev_seq <= 20'h00000;
      ev_chan <= 8'h00;
      ev_man <= 1'b0;
      ev_time <= 48'h000000000000;
    end else if (!evt_busy && evt_valid_in) begin
      evt_busy <= 1'b1;
      ev_idx <= 5'h00;
      ev_kind <= evt_kind_in;
      ev_unit <= evt_unit_in;
      ev_seq <= evt_seq_in;
      ev_chan <= evt_chan_in;
      ev_man <= evt_manual_in;
      ev_time <= evt_time_in;
    end else if (evt_push) begin
      ev_idx <= ev_idx + 5'h01;
      if (ev_idx == 5'(EVT_LEN - 1)) begin
        evt_busy <= 1'b0;
      end
    end
  end

  always_comb begin
    case (ev_idx)
      5'h00: ev_char = (ev_kind == KIND_NEW) ? CH_N : (ev_kind == KIND_SYNC) ? CH_S : CH_T;
      5'h01: ev_char = dig(ev_unit[15:12]);
      5'h02: ev_char = dig(ev_unit[11:8]);
      5'h03: ev_char = dig(ev_unit[7:4]);
      5'h04: ev_char = dig(ev_unit[3:0]);
      5'h06: ev_char = dig(ev_seq[19:16]);
      5'h07: ev_char = dig(ev_seq[15:12]);
      5'h08: ev_char = dig(ev_seq[11:8]);
      5'h09: ev_char = dig(ev_seq[7:4]);
      5'h0A: ev_char = dig(ev_seq[3:0]);
      5'h0C: ev_char = ev_man ? CH_M : dig(ev_chan[7:4]);
      5'h0D: ev_char = dig(ev_chan[3:0]);
      5'h0F: ev_char = dig(ev_time[47:44]);
      5'h10: ev_char = dig(ev_time[43:40]);
      5'h11: ev_char = CH_COLON;
      5'h12: ev_char = dig(ev_time[39:36]);
      5'h13: ev_char = dig(ev_time[35:32]);
      5'h14: ev_char = CH_COLON;
      5'h15: ev_char = dig(ev_time[31:28]);
      5'h16: ev_char = dig(ev_time[27:24]);
      5'h17: ev_char = CH_DOT;
      5'h18: ev_char = dig(ev_time[23:20]);
      5'h19: ev_char = dig(ev_time[19:16]);
      5'h1A: ev_char = dig(ev_time[15:12]);
      5'h1B: ev_char = dig(ev_time[11:8]);
      5'h1C: ev_char = dig(ev_time[7:4]);
      5'h1D: ev_char = dig(ev_time[3:0]);
      5'h1E: ev_char = CH_CR;
      default: ev_char = CH_SP;
    endcase
  end

  // ---------------------------------------------------------------
  // printer buffer, drained only while the printer is ready
  // ---------------------------------------------------------------
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr;
  logic [FIFO_AW-1:0] rd_ptr;
  logic [FIFO_AW:0] fifo_cnt;
  logic fifo_full;
  logic fifo_empty;
  logic push;
  logic [7:0] wdata;
  logic prn_tx_rdy;
  logic prn_take;

  assign fifo_full = (fifo_cnt == (FIFO_AW + 1)'(FIFO_DEPTH));
  assign fifo_empty = (fifo_cnt == '0);
  // a full buffer stalls the framer, never drops a character
  assign evt_push = evt_busy && !fifo_full;
  assign fwd_push = !evt_busy && fwd_prn_v && !fifo_full;
  assign push = evt_push || fwd_push;
  assign wdata = evt_busy ? ev_char : fwd_byte;
  assign prn_take = prn_rdy && !fifo_empty && prn_tx_rdy;

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      fifo_mem[wr_ptr] <= wdata;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (prn_take) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !prn_take) begin
        fifo_cnt <= fifo_cnt + 1'b1;
      end else if (!push && prn_take) begin
        fifo_cnt <= fifo_cnt - 1'b1;
      end
    end
  end

  tsor_uart_tx #(.BIT_CYC_P(BIT_CYC_P)) u_prn_tx (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .valid_in(prn_take),
    .data_in(fifo_mem[rd_ptr]),
    .ready_out(prn_tx_rdy),
    .tx_out(prn_tx_out)
  );

  // ---------------------------------------------------------------
  // running time record on the display port
  // ---------------------------------------------------------------
  logic [31:0] run_div;
  logic run_pend;
  logic run_busy;
  logic [3:0] run_idx;
  logic [27:0] run_tod;
  logic [7:0] run_char;
  logic disp_rdy;
  logic run_take;

  assign run_take = run_busy && disp_rdy;
  assign fwd_disp_take = !run_busy && fwd_disp_v && disp_rdy;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_div <= '0;
      run_pend <= 1'b0;
    end else if (!run_en) begin
      run_div <= '0;
      run_pend <= 1'b0;
    end else if (run_div == 32'(RUN_CYC_P - 1)) begin
      run_div <= '0;
      run_pend <= 1'b1;
    end else begin
      run_div <= run_div + 32'h1;
      if (!run_busy) begin
        run_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_busy <= 1'b0;
      run_idx <= 4'h0;
      run_tod <= 28'h0000000;
    end else if (!run_busy && run_pend && run_en) begin
      run_busy <= 1'b1;
      run_idx <= 4'h0;
      run_tod <= tod_in;
    end else if (run_take) begin
      run_idx <= run_idx + 4'h1;
      if (run_idx == 4'(RUN_LEN - 1)) begin
        run_busy <= 1'b0;
      end
    end
  end

  always_comb begin
    case (run_idx)
      4'h0: run_char = CH_R;
      4'h2: run_char = dig(run_tod[27:24]);
      4'h3: run_char = dig(run_tod[23:20]);
      4'h4: run_char = CH_COLON;
      4'h5: run_char = dig(run_tod[19:16]);
      4'h6: run_char = dig(run_tod[15:12]);
      4'h7: run_char = CH_COLON;
      4'h8: run_char = dig(run_tod[11:8]);
      4'h9: run_char = dig(run_tod[7:4]);
      4'hA: run_char = CH_DOT;
      4'hB: run_char = dig(run_tod[3:0]);
      4'hC: run_char = CH_CR;
      default: run_char = CH_SP;
    endcase
  end

  tsor_uart_tx #(.BIT_CYC_P(BIT_CYC_P)) u_disp_tx (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .valid_in(run_busy || fwd_disp_v),
    .data_in(run_busy ? run_char : fwd_byte),
    .ready_out(disp_rdy),
    .tx_out(disp_tx_out)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_evt_last;
    evt_push && (ev_idx == 5'h1E);
  endsequence

  property p_prn_gate;
    !prn_rdy |-> !prn_take;
  endproperty
  a_prn_gate: assert property (p_prn_gate) else $error("printer sent while not ready");

  property p_prn_hold;
    !prn_rdy |=> $stable(rd_ptr) && (fifo_cnt >= $past(fifo_cnt));
  endproperty
  a_prn_hold: assert property (p_prn_hold) else $error("buffer drained while closed");

  property p_prn_drain;
    prn_rdy && !fifo_empty && prn_tx_rdy |=> rd_ptr == $past(rd_ptr) + 1'b1;
  endproperty
  a_prn_drain: assert property (p_prn_drain) else $error("buffer not drained");

  property p_run_on;
    is_pl && link == TSOR_LINK_NONE |=> run_en;
  endproperty
  a_run_on: assert property (p_run_on) else $error("running time not enabled");

  property p_run_off;
    is_p1 && link == TSOR_LINK_NONE |=> !run_en ##1 !run_pend;
  endproperty
  a_run_off: assert property (p_run_off) else $error("running time not inhibited");

  property p_linked_quiet;
    frame_end && link != TSOR_LINK_NONE && !is_lx |=> !$rose(ack_pend);
  endproperty
  a_linked_quiet: assert property (p_linked_quiet) else $error("answer while linked");

  property p_unlink;
    is_lx |=> link == TSOR_LINK_NONE && ack_pend && ack_byte == CH_ACK;
  endproperty
  a_unlink: assert property (p_unlink) else $error("unlink not done");

  property p_evt_end;
    s_evt_last |-> wdata == CH_CR ##1 !evt_busy;
  endproperty
  a_evt_end: assert property (p_evt_end) else $error("event record end wrong");

  property p_manual;
    evt_push && ev_idx == 5'h0C && ev_man |-> wdata == CH_M;
  endproperty
  a_manual: assert property (p_manual) else $error("manual channel letter missing");

  property p_run_end;
    run_take && run_idx == 4'hC |-> run_char == CH_CR ##1 !run_busy;
  endproperty
  a_run_end: assert property (p_run_end) else $error("running record end wrong");

  property p_run_idle;
    !run_en && !run_busy |=> !run_busy;
  endproperty
  a_run_idle: assert property (p_run_idle) else $error("running record while disabled");

  property p_fwd_disp;
    fwd_ok && link == TSOR_LINK_DISP |=> fwd_disp_v && fwd_byte == $past(rx_byte);
  endproperty
  a_fwd_disp: assert property (p_fwd_disp) else $error("display text not forwarded");

endmodule

// ### hw/tsor_pkg.sv
// constants and types shared by the timer serial output router
package tsor_pkg;

  // ---------------------------------------------------------------
  // clock and serial timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD = 9600;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
  // nearest whole cycle keeps the bit-rate error lowest
  localparam int BIT_CYC = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int RUN_PERIOD_MS = 100;
  localparam int RUN_CYC = (CLK_HZ / 1000) * RUN_PERIOD_MS;

  // ---------------------------------------------------------------
  // record and buffer sizes
  // ---------------------------------------------------------------
  localparam int EVT_LEN = 31;
  localparam int RUN_LEN = 13;
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_AW = 6;

  // ---------------------------------------------------------------
  // characters
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_L = 8'h4C;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_X = 8'h58;

  // ---------------------------------------------------------------
  // record kinds and states
  // ---------------------------------------------------------------
  localparam logic [1:0] KIND_NEW = 2'h0;
  localparam logic [1:0] KIND_SYNC = 2'h1;
  localparam logic [1:0] KIND_TIME = 2'h2;

  typedef enum logic [1:0] {TSOR_LINK_NONE, TSOR_LINK_PRN, TSOR_LINK_DISP} tsor_link_t;
  typedef enum logic [1:0] {TSOR_RX_IDLE, TSOR_RX_START, TSOR_RX_DATA, TSOR_RX_STOP} tsor_rx_t;

endpackage

// ### dv/tsor_peer.sv
// serial receiver model for the printer, display and host sides
`timescale 1ns/1ps
module tsor_peer #(
  parameter int BIT_CYC_P = 8
) (
  // clock
  input wire logic core_clk_in,
  // line and byte seen
  input wire logic line_in,
  output logic got_out,
  output logic [7:0] byte_out
);
  initial begin
    got_out = 1'b0;
    byte_out = 8'h00;
    forever begin
      @(negedge line_in);
      // sample mid-bit, lsb first, no parity
      repeat (BIT_CYC_P / 2) @(posedge core_clk_in);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC_P) @(posedge core_clk_in);
        if (i < 8) byte_out[i] = line_in;
        else if (!line_in) byte_out = 8'hFF;
      end
      got_out <= 1'b1;
      @(posedge core_clk_in);
      got_out <= 1'b0;
    end
  end
endmodule

// ### dv/timer_serial_output_router_tb.sv
// self-checking bench for the timer serial output router
`timescale 1ns/1ps
module timer_serial_output_router_tb;
  import tsor_pkg::*;
  localparam int BC = 8;
  logic core_clk_in, rst_in, host_rx_in, prn_ready_in, evt_valid_in, evt_manual_in;
  logic host_tx_out, prn_tx_out, disp_tx_out, evt_ready_out;
  logic link_prn_out, link_disp_out, run_en_out;
  logic [1:0] evt_kind_in;
  logic [15:0] evt_unit_in;
  logic [19:0] evt_seq_in;
  logic [7:0] evt_chan_in;
  logic [47:0] evt_time_in, td;
  logic [27:0] tod_in;
  logic [7:0] prn_q[$], disp_q[$], host_q[$], exp_q[$];
  logic [2:0] got;
  logic [7:0] gb[3];
  int err_total, num_checks;

  tsor_top #(.BIT_CYC_P(BC), .RUN_CYC_P(2000)) i_dut (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .host_rx_in(host_rx_in), .host_tx_out(host_tx_out),
    .prn_ready_in(prn_ready_in), .prn_tx_out(prn_tx_out), .disp_tx_out(disp_tx_out),
    .evt_valid_in(evt_valid_in), .evt_ready_out(evt_ready_out), .evt_kind_in(evt_kind_in),
    .evt_unit_in(evt_unit_in), .evt_seq_in(evt_seq_in), .evt_chan_in(evt_chan_in),
    .evt_manual_in(evt_manual_in), .evt_time_in(evt_time_in), .tod_in(tod_in),
    .link_prn_out(link_prn_out), .link_disp_out(link_disp_out), .run_en_out(run_en_out));
  // one bit time on every port
  tsor_peer #(.BIT_CYC_P(BC)) i_prn (.core_clk_in(core_clk_in), .line_in(prn_tx_out),
    .got_out(got[0]), .byte_out(gb[0]));
  tsor_peer #(.BIT_CYC_P(BC)) i_disp (.core_clk_in(core_clk_in), .line_in(disp_tx_out),
    .got_out(got[1]), .byte_out(gb[1]));
  tsor_peer #(.BIT_CYC_P(BC)) i_host (.core_clk_in(core_clk_in), .line_in(host_tx_out),
    .got_out(got[2]), .byte_out(gb[2]));

  always @(posedge core_clk_in) begin
    if (got[0]) prn_q.push_back(gb[0]);
    if (got[1]) disp_q.push_back(gb[1]);
    if (got[2]) host_q.push_back(gb[2]);
  end

  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  task summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value t=%0t got %h expected %h", $time, seen, exp);
    end
  endtask

  // waits for as many bytes as the model expects, then compares in order
  task automatic cmp_q(ref logic [7:0] q[$]);
    for (int i = 0; i < 20000 && q.size() < exp_q.size(); i++) @(posedge core_clk_in);
    if (q.size() < exp_q.size()) begin
      err_total++;
      summarize();
    end
    foreach (exp_q[i]) check(q[i], exp_q[i]);
    q.delete();
    exp_q.delete();
  endtask

  task dig(input logic [47:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back({4'h3, v[4*i+:4]});
  endtask

  function automatic logic [47:0] rbcd();
    for (int i = 0; i < 12; i++) rbcd[4*i+:4] = 4'($urandom % 10);
  endfunction

  task hb(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_in) host_rx_in <= f[i];
      repeat (BC - 1) @(posedge core_clk_in);
    end
    repeat (20 * BC) @(posedge core_clk_in);
  endtask

  task cmd(input logic [7:0] a, input logic [7:0] b, input logic [7:0] ans);
    hb(CH_STX);
    hb(a);
    hb(b);
    hb(a + b);
    hb(CH_ETX);
    if (ans != 8'h00) exp_q.push_back(ans);
    else repeat (200) @(posedge core_clk_in);
    if (ans == 8'h00) check(8'(host_q.size()), 8'h00);
    cmp_q(host_q);
  endtask

  task evt(input logic m);
    logic [47:0] u, s, c, t;
    logic [1:0] k;
    u = rbcd();
    s = rbcd();
    c = rbcd();
    t = rbcd();
    k = 2'($urandom);
    @(posedge core_clk_in);
    evt_valid_in <= 1'b1;
    evt_kind_in <= k;
    evt_unit_in <= u[15:0];
    evt_seq_in <= s[19:0];
    evt_chan_in <= c[7:0];
    evt_manual_in <= m;
    evt_time_in <= t;
    exp_q.push_back(k == 2'h0 ? CH_N : k == 2'h1 ? CH_S : CH_T);
    dig(u, 4);
    exp_q.push_back(CH_SP);
    dig(s, 5);
    exp_q.push_back(CH_SP);
    if (m) exp_q.push_back(CH_M);
    dig(c, m ? 1 : 2);
    exp_q.push_back(CH_SP);
    dig(t >> 40, 2);
    exp_q.push_back(CH_COLON);
    dig(t >> 32, 2);
    exp_q.push_back(CH_COLON);
    dig(t >> 24, 2);
    exp_q.push_back(CH_DOT);
    dig(t, 6);
    exp_q.push_back(CH_CR);
    for (int i = 0; i <= 200; i++) begin
      @(negedge core_clk_in);
      if (evt_ready_out === 1'b1) break;
      if (i == 200) begin
        err_total++;
        summarize();
      end
    end
    // taken at this edge, so the request drops here
    @(posedge core_clk_in) evt_valid_in <= 1'b0;
  endtask

  initial begin
    {rst_in, host_rx_in} = 2'h3;
    {prn_ready_in, evt_valid_in, evt_manual_in, evt_kind_in} = 5'h00;
    {evt_unit_in, evt_seq_in, evt_chan_in, evt_time_in, tod_in} = 120'h0;
    err_total = 0;
    num_checks = 0;
    void'($urandom(32'h174e));
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    check({5'h00, link_prn_out, link_disp_out, run_en_out}, 8'h00);
    // records held while the printer is not ready
    evt(1'b0);
    evt(1'b1);
    @(posedge core_clk_in) evt_valid_in <= 1'b0;
    repeat (400) @(posedge core_clk_in);
    check(8'(prn_q.size()), 8'h00);
    prn_ready_in <= 1'b1;
    cmp_q(prn_q);
    $display("test records done");
    cmd(CH_L, CH_P, CH_ACK);
    check({7'h00, link_prn_out}, 8'h01);
    prn_ready_in <= 1'b0;
    cmd(CH_P, CH_L, 8'h00);
    hb(8'h41);
    hb(8'h7A);
    cmd(CH_L, CH_X, CH_ACK);
    check({6'h00, link_prn_out, run_en_out}, 8'h00);
    check(8'(prn_q.size()), 8'h00);
    prn_ready_in <= 1'b1;
    exp_q = {8'h41, 8'h7A};
    cmp_q(prn_q);
    hb(8'h42);
    cmd(CH_X, CH_X, CH_NAK);
    check(8'(prn_q.size()), 8'h00);
    $display("test printer link done");
    cmd(CH_L, CH_L, CH_ACK);
    check({7'h00, link_disp_out}, 8'h01);
    td = rbcd();
    hb(td[7:0] | 8'h20);
    exp_q.push_back(td[7:0] | 8'h20);
    cmp_q(disp_q);
    cmd(CH_L, CH_X, CH_ACK);
    $display("test display link done");
    @(posedge core_clk_in) tod_in <= td[27:0];
    cmd(CH_P, CH_L, CH_ACK);
    check({7'h00, run_en_out}, 8'h01);
    exp_q = {CH_R, CH_SP};
    dig(td >> 20, 2);
    exp_q.push_back(CH_COLON);
    dig(td >> 12, 2);
    exp_q.push_back(CH_COLON);
    dig(td >> 4, 2);
    exp_q.push_back(CH_DOT);
    dig(td, 1);
    exp_q.push_back(CH_CR);
    cmp_q(disp_q);
    cmd(CH_P, CH_ONE, CH_ACK);
    repeat (2000) @(posedge core_clk_in);
    disp_q.delete();
    repeat (4000) @(posedge core_clk_in);
    check({7'h00, run_en_out}, 8'h00);
    check(8'(disp_q.size()), 8'h00);
    $display("test running time done");
    summarize();
  end
endmodule
